//--- xp_cfg.svh
// constants of the serial i/o expander: command codes, offsets, resets
`ifndef XP_CFG_SVH
`define XP_CFG_SVH

// ----------------------------------------------------------------------
// serial side: command byte codes and slave address
// ----------------------------------------------------------------------
`define XP_CMD_INPUT    2'h0
`define XP_CMD_OUTPUT   2'h1
`define XP_CMD_POLAR    2'h2
`define XP_CMD_DIR      2'h3
`define XP_CMD_LAST     8'h03
// fixed upper four address bits, value arbitrary
`define XP_ADDR_FIXED   4'h4
`define XP_BIT_LAST     4'h8

// ----------------------------------------------------------------------
// register bus byte offsets
// ----------------------------------------------------------------------
`define XP_AV_INPUT     5'h00
`define XP_AV_OUTPUT    5'h04
`define XP_AV_POLAR     5'h08
`define XP_AV_DIR       5'h0C
`define XP_AV_STAT      5'h10
`define XP_AV_MASK      5'h14

// ----------------------------------------------------------------------
// status bit positions and reset values
// ----------------------------------------------------------------------
`define XP_ST_CHANGE    0
`define XP_ST_WRITE     1
`define XP_ST_STOP      2
`define XP_RST_DIR      8'hFF
`define XP_RST_OUTPUT   8'hFF
`define XP_RST_POLAR    8'h00
`define XP_RST_CAPTURE  8'hFF
`define XP_RST_MASK     3'h0

`endif

//--- xp_expander.sv
// eight-bit serial i/o expander with register bus and interrupt
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "xp_cfg.svh"

// How it works
// - after reset every pin is an input and none is driven.
// - each direction bit decides whether its pin is driven or released.
// - direction, input, output and polarity registers are eight bits, one per pin.
// - the input register follows the pins and the output register holds driven values.
// - a set polarity bit inverts that pin in the input register.
// - every register reads back its current contents.
// - reset returns all registers to defaults and idles the serial machine.
// - the interrupt is asserted while an input pin differs from the captured input.
// - the interrupt is active low and open drain.
// - three address straps form the low bits of the seven-bit slave address.
// - an output pin keeps its last written value until rewritten.
module xp_expander import xp_pkg::*; #(
	parameter int PORT_W = 8
) (
	input  wire logic              sys_clk_i,
	input  wire logic              srst_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	input  wire logic              addr_strap_0_i,
	input  wire logic              addr_strap_1_i,
	input  wire logic              addr_strap_2_i,
	input  wire logic [PORT_W-1:0] port_pins_i,
	output logic      [PORT_W-1:0] port_pins_o,
	output logic      [PORT_W-1:0] port_pins_oe_o,
	output logic                   int_n_o,
	output logic                   int_n_oe_o,
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   irq_o
);

	// registers are eight bits wide by construction
	if (PORT_W != 8) begin : g_chk
		$error("xp_expander: PORT_W must be 8");
	end

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	logic [1:0]        bus_s;
	logic [2:0]        strap_s;
	logic [PORT_W-1:0] pins_s;

	xp_sync #(.WIDTH(2)) u_sync_bus (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.d_i       ({scl_i, sda_i}),
		.q_o       (bus_s)
	);
	xp_sync #(.WIDTH(3)) u_sync_strap (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.d_i       ({addr_strap_2_i, addr_strap_1_i, addr_strap_0_i}),
		.q_o       (strap_s)
	);
	xp_sync #(.WIDTH(PORT_W)) u_sync_pins (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.d_i       (port_pins_i),
		.q_o       (pins_s)
	);

	// ------------------------------------------------------------------
	// state declarations
	// ------------------------------------------------------------------
	logic [PORT_W-1:0] dir_r,  dir_nxt;
	logic [PORT_W-1:0] out_r,  out_nxt;
	logic [PORT_W-1:0] pol_r,  pol_nxt;
	logic [PORT_W-1:0] cap_r,  cap_nxt;
	logic [PORT_W-1:0] in_val;
	logic [2:0]        stat_r, stat_nxt;
	logic [2:0]        mask_r, mask_nxt;
	logic              wait_r, wait_nxt;
	logic [31:0]       rdat_r, rdat_nxt;
	logic              pend_r, pend_nxt;
	logic              irq_r,  irq_nxt;
	xp_state_type      st_r,   st_nxt;
	logic [3:0]        cnt_r,  cnt_nxt;
	logic [7:0]        sh_r,   sh_nxt;
	logic [7:0]        tx_r,   tx_nxt;
	logic [1:0]        sel_r,  sel_nxt;
	logic              rw_r,   rw_nxt;
	logic              nak_r,  nak_nxt;
	logic              oe_r,   oe_nxt;
	logic              scl_q,  sda_q;
	logic              scl_rise, scl_fall, bus_start, bus_stop;
	logic              i2c_wr, i2c_cap;
	logic              av_ack, av_cap;

	// ------------------------------------------------------------------
	// port pins
	// ------------------------------------------------------------------
	for (genvar i = 0; i < PORT_W; i++) begin : g_pin
		xp_pin_cell u_cell (
			.sys_clk_i (sys_clk_i),
			.srst_i    (srst_i),
			.dir_i     (dir_r[i]),
			.out_i     (out_r[i]),
			.pol_i     (pol_r[i]),
			.pin_i     (pins_s[i]),
			.pin_o     (port_pins_o[i]),
			.pin_oe_o  (port_pins_oe_o[i]),
			.in_o      (in_val[i])
		);
	end

	function automatic logic [7:0] reg_sel(input logic [1:0] s, input logic [7:0] iv,
		input logic [7:0] ov, input logic [7:0] pv, input logic [7:0] dv);
		logic [7:0] r;
		r = iv;
		case (s)
			`XP_CMD_OUTPUT: r = ov;
			`XP_CMD_POLAR:  r = pv;
			`XP_CMD_DIR:    r = dv;
			default:        r = iv;
		endcase
		return r;
	endfunction : reg_sel

	// ------------------------------------------------------------------
	// serial slave
	// ------------------------------------------------------------------
	assign scl_rise  = bus_s[1] & ~scl_q;
	assign scl_fall  = ~bus_s[1] & scl_q;
	assign bus_start = bus_s[1] & scl_q & sda_q & ~bus_s[0];
	assign bus_stop  = bus_s[1] & scl_q & ~sda_q & bus_s[0];

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		sh_nxt  = sh_r;
		tx_nxt  = tx_r;
		sel_nxt = sel_r;
		rw_nxt  = rw_r;
		nak_nxt = nak_r;
		oe_nxt  = oe_r;
		i2c_wr  = 1'b0;
		i2c_cap = 1'b0;
		if (bus_stop) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else if (bus_start) begin
			st_nxt  = ST_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end else begin
			case (st_r)
				ST_ADDR, ST_CMD, ST_WDATA: begin
					if (scl_rise) begin
						sh_nxt  = {sh_r[6:0], bus_s[0]};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `XP_BIT_LAST) begin
						oe_nxt = 1'b1;
						if (st_r == ST_ADDR) begin
							// straps give the low address bits
							if (sh_r[7:1] == {`XP_ADDR_FIXED, strap_s}) begin
								st_nxt = ST_ACK_A;
								rw_nxt = sh_r[0];
							end else begin
								st_nxt = ST_IDLE;
								oe_nxt = 1'b0;
							end
						end else if (st_r == ST_CMD) begin
							st_nxt = ST_ACK_C;
							if (sh_r <= `XP_CMD_LAST) begin
								sel_nxt = sh_r[1:0];
							end
						end else begin
							st_nxt = ST_ACK_W;
							i2c_wr = 1'b1;
						end
					end
				end
				ST_ACK_A, ST_ACK_C, ST_ACK_W: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						oe_nxt  = 1'b0;
						if (st_r == ST_ACK_A && rw_r) begin
							st_nxt  = ST_RDATA;
							tx_nxt  = reg_sel(sel_r, in_val, out_r, pol_r, dir_r);
							oe_nxt  = ~tx_nxt[7];
							i2c_cap = (sel_r == `XP_CMD_INPUT);
						end else if (st_r == ST_ACK_A) begin
							st_nxt = ST_CMD;
						end else begin
							st_nxt = ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						cnt_nxt = cnt_r + 4'h1;
						tx_nxt  = {tx_r[6:0], 1'b0};
						oe_nxt  = ~tx_r[6];
						if (cnt_r == 4'h7) begin
							st_nxt = ST_RACK;
							oe_nxt = 1'b0;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nak_nxt = bus_s[0];
					end else if (scl_fall) begin
						cnt_nxt = 4'h0;
						if (nak_r) begin
							st_nxt = ST_IDLE;
						end else begin
							st_nxt  = ST_RDATA;
							tx_nxt  = reg_sel(sel_r, in_val, out_r, pol_r, dir_r);
							oe_nxt  = ~tx_nxt[7];
							i2c_cap = (sel_r == `XP_CMD_INPUT);
						end
					end
				end
				default: begin
					st_nxt = ST_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	// reset idles the serial machine
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_r  <= ST_IDLE;
			cnt_r <= 4'h0;
			sh_r  <= 8'h00;
			tx_r  <= 8'h00;
			sel_r <= `XP_CMD_INPUT;
			rw_r  <= 1'b0;
			nak_r <= 1'b1;
			oe_r  <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r  <= sh_nxt;
			tx_r  <= tx_nxt;
			sel_r <= sel_nxt;
			rw_r  <= rw_nxt;
			nak_r <= nak_nxt;
			oe_r  <= oe_nxt;
			scl_q <= bus_s[1];
			sda_q <= bus_s[0];
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = oe_r;

	// ------------------------------------------------------------------
	// registers and bus slave
	// ------------------------------------------------------------------
	// one wait cycle, then the answer; readdata stands with it
	assign av_ack = (avs_read | avs_write) & ~wait_r;
	assign av_cap = av_ack & avs_read & (avs_address[4:2] == `XP_AV_INPUT >> 2);

	always_comb begin
		dir_nxt  = dir_r;
		out_nxt  = out_r;
		pol_nxt  = pol_r;
		mask_nxt = mask_r;
		stat_nxt = stat_r;
		rdat_nxt = rdat_r;
		cap_nxt  = cap_r;
		wait_nxt = ~((avs_read | avs_write) & wait_r);
		if (i2c_cap || av_cap) begin
			cap_nxt = pins_s;
		end
		if (avs_read && wait_r) begin
			case ({avs_address[4:2], 2'b00})
				`XP_AV_INPUT:  rdat_nxt = {24'h0, in_val};
				`XP_AV_OUTPUT: rdat_nxt = {24'h0, out_r};
				`XP_AV_POLAR:  rdat_nxt = {24'h0, pol_r};
				`XP_AV_DIR:    rdat_nxt = {24'h0, dir_r};
				`XP_AV_STAT:   rdat_nxt = {29'h0, stat_r};
				`XP_AV_MASK:   rdat_nxt = {29'h0, mask_r};
				default:       rdat_nxt = 32'h0;
			endcase
		end
		if (av_ack && avs_write) begin
			case ({avs_address[4:2], 2'b00})
				`XP_AV_OUTPUT: out_nxt  = avs_writedata[7:0];
				`XP_AV_POLAR:  pol_nxt  = avs_writedata[7:0];
				`XP_AV_DIR:    dir_nxt  = avs_writedata[7:0];
				`XP_AV_MASK:   mask_nxt = avs_writedata[2:0];
				default:       mask_nxt = mask_r;
			endcase
		end
		// serial write lands after a bus write in the same cycle
		if (i2c_wr) begin
			case (sel_r)
				`XP_CMD_OUTPUT: out_nxt = sh_r;
				`XP_CMD_POLAR:  pol_nxt = sh_r;
				`XP_CMD_DIR:    dir_nxt = sh_r;
				default:        out_nxt = out_nxt;
			endcase
		end
		// clear on read, but a new event in that cycle survives
		if (av_ack && avs_read && avs_address[4:2] == `XP_AV_STAT >> 2) begin
			stat_nxt = 3'h0;
		end
		if (pend_nxt && !pend_r) begin
			stat_nxt[`XP_ST_CHANGE] = 1'b1;
		end
		if (i2c_wr) begin
			stat_nxt[`XP_ST_WRITE] = 1'b1;
		end
		if (bus_stop && st_r != ST_IDLE) begin
			stat_nxt[`XP_ST_STOP] = 1'b1;
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	// an input-configured pin that moved from the capture
	assign pend_nxt = |((pins_s ^ cap_r) & dir_r);

	// defaults: all inputs, no inversion
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			dir_r  <= `XP_RST_DIR;
			out_r  <= `XP_RST_OUTPUT;
			pol_r  <= `XP_RST_POLAR;
			cap_r  <= `XP_RST_CAPTURE;
			mask_r <= `XP_RST_MASK;
			stat_r <= 3'h0;
			wait_r <= 1'b1;
			rdat_r <= 32'h0;
			pend_r <= 1'b0;
			irq_r  <= 1'b0;
		end else begin
			dir_r  <= dir_nxt;
			out_r  <= out_nxt;
			pol_r  <= pol_nxt;
			cap_r  <= cap_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			wait_r <= wait_nxt;
			rdat_r <= rdat_nxt;
			pend_r <= pend_nxt;
			irq_r  <= irq_nxt;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdat_r;
	assign irq_o           = irq_r;
	assign int_n_o         = 1'b0;
	assign int_n_oe_o      = pend_r;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	AST_RESET_DEFAULTS:
	assert property (@(posedge sys_clk_i) srst_i |=> dir_r == 8'hFF && pol_r == 8'h00
		&& st_r == ST_IDLE && !sda_oe_o)
		else $error("reset did not restore defaults");

	AST_NO_DRIVE_AFTER_RESET:
	assert property (@(posedge sys_clk_i) srst_i ##1 srst_i |=> port_pins_oe_o == 8'h00)
		else $error("pin driven after reset");

	AST_DIR_DRIVE:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!$past(srst_i) |-> port_pins_oe_o == ~$past(dir_r))
		else $error("pin drive does not follow direction");

	AST_OUT_LATCH:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!i2c_wr && !(av_ack && avs_write) |=> $stable(out_r))
		else $error("output latch changed without a write");

	AST_POLARITY:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!$past(srst_i) |-> in_val == ($past(pins_s) ^ $past(pol_r)))
		else $error("input register polarity wrong");

	AST_INT_FOLLOWS:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(|((pins_s ^ cap_r) & dir_r)) |=> int_n_oe_o && !int_n_o)
		else $error("interrupt not asserted on changed input");

	AST_INT_RELEASE:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		(i2c_cap || av_cap) ##1 (pins_s == $past(pins_s)) |=> !int_n_oe_o)
		else $error("interrupt not released after input read");

	AST_ADDR_ACK:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st_r == ST_ADDR && scl_fall && cnt_r == 4'h8 && !bus_stop && !bus_start
		&& sh_r[7:1] == {`XP_ADDR_FIXED, strap_s} |=> st_r == ST_ACK_A && sda_oe_o)
		else $error("own address not acknowledged");

	AST_READBACK_DIR:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		avs_read && wait_r && avs_address == `XP_AV_DIR && !i2c_wr
		|=> !avs_waitrequest && avs_readdata == {24'h0, $past(dir_r)})
		else $error("direction register read back wrong");

	AST_CMD_SELECT:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		st_r == ST_CMD && scl_fall && cnt_r == 4'h8 && !bus_stop && !bus_start
		&& sh_r == 8'h03 |=> sel_r == `XP_CMD_DIR ##0 st_r == ST_ACK_C)
		else $error("command byte did not select register");

endmodule : xp_expander

`default_nettype wire

//--- xp_expander_tb_top.sv
// self-checking bench of the serial i/o expander
`timescale 1ns/10ps
`default_nettype none
`include "xp_cfg.svh"

`define CHK(nm, e, a) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		n_fail++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, (e), (a)); \
	end \
end

module xp_expander_tb_top;
	typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} xp_row_type;

	logic        sys_clk_i = 1'b0;
	logic        srst_i    = 1'b1;
	logic        m_scl, m_sda_oe, sda_oe, int_n, int_oe, irq, ack, wr_ack, sda_v;
	logic [2:0]  strap     = 3'b101;
	logic [7:0]  pin_ext   = 8'hFF;
	logic [7:0]  p_o, p_oe, rx;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read    = 1'b0;
	logic        avs_write   = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic        avs_waitrequest;
	int          n_fail, check_count;
	wire         sda  = ~(m_sda_oe | sda_oe);
	wire  [7:0]  pins = (p_oe & p_o) | (~p_oe & pin_ext);
	wire  [7:0]  ad_w = {`XP_ADDR_FIXED, 3'b101, 1'b0};
	xp_row_type  rows [6] = '{'{`XP_AV_INPUT, 8'h00, 8'hFF}, '{`XP_AV_OUTPUT, 8'hA5, 8'hA5},
		'{`XP_AV_DIR, 8'h0F, 8'h0F}, '{`XP_AV_POLAR, 8'h3C, 8'h3C},
		'{`XP_AV_MASK, 8'hFF, 8'h07}, '{5'h18, 8'hFF, 8'h00}};

	always #20 sys_clk_i = ~sys_clk_i;

	xp_expander i_xp_expander (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .scl_i(m_scl),
		.sda_i(sda), .sda_o(sda_v), .sda_oe_o(sda_oe), .addr_strap_0_i(strap[0]),
		.addr_strap_1_i(strap[1]), .addr_strap_2_i(strap[2]), .port_pins_i(pins),
		.port_pins_o(p_o), .port_pins_oe_o(p_oe), .int_n_o(int_n), .int_n_oe_o(int_oe),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq_o(irq));

	xp_i2c_master_model i_xp_i2c_master_model (.clk_i(sys_clk_i), .sda_i(sda),
		.scl_o(m_scl), .sda_oe_o(m_sda_oe));

	// ------------------------------------------------------------
	// bus helpers; an idle edge after each access avoids double drive
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc

	task automatic av(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		`CHK("waitrequest", 1'b0, avs_waitrequest)
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk_i);
	endtask : av

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	initial begin
		cyc(20000);
		n_fail++;
		final_report();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		cyc(8);
		srst_i <= 1'b0;
		cyc(1);
		`CHK("reset pin drive", 8'h00, p_oe)
		foreach (rows[i]) begin
			av(1'b1, rows[i].a, rows[i].d);
			av(1'b0, rows[i].a, 8'h00);
			`CHK("row readback", {24'h0, rows[i].e}, q)
		end
		`CHK("pin drive", 8'hF0, p_oe)
		`CHK("pin value", 8'hA5, p_o)
		$display("test register rows done");
		pin_ext <= 8'h06;
		cyc(8);
		av(1'b0, `XP_AV_INPUT, 8'h00);
		`CHK("input polarity", 32'h9A, q)
		pin_ext <= 8'h07;
		cyc(8);
		`CHK("int asserted", 1'b1, int_oe)
		`CHK("int level", 1'b0, int_n)
		`CHK("irq raised", 1'b1, irq)
		av(1'b0, `XP_AV_STAT, 8'h00);
		`CHK("status change", 32'h1, q)
		cyc(2);
		`CHK("irq cleared", 1'b0, irq)
		pin_ext <= 8'h06;
		cyc(8);
		`CHK("int pins back", 1'b0, int_oe)
		pin_ext <= 8'h04;
		cyc(8);
		av(1'b0, `XP_AV_INPUT, 8'h00);
		`CHK("input again", 32'h98, q)
		cyc(4);
		`CHK("int after read", 1'b0, int_oe)
		av(1'b1, `XP_AV_MASK, 8'h00);
		pin_ext <= 8'h06;
		cyc(8);
		`CHK("masked irq", 1'b0, irq)
		$display("test interrupt done");
		i_xp_i2c_master_model.start();
		i_xp_i2c_master_model.xfer(ad_w, 1'b1, rx, ack);
		`CHK("addr ack", 1'b0, ack)
		`CHK("sda value", 1'b0, sda_v)
		i_xp_i2c_master_model.xfer({6'h0, `XP_CMD_OUTPUT}, 1'b1, rx, ack);
		i_xp_i2c_master_model.xfer(8'h3C, 1'b1, rx, wr_ack);
		`CHK("data ack", 1'b0, wr_ack)
		i_xp_i2c_master_model.stop();
		cyc(4);
		`CHK("serial out pins", 8'h3C, p_o)
		i_xp_i2c_master_model.start();
		i_xp_i2c_master_model.xfer(ad_w, 1'b1, rx, ack);
		i_xp_i2c_master_model.xfer({6'h0, `XP_CMD_DIR}, 1'b1, rx, ack);
		i_xp_i2c_master_model.start();
		i_xp_i2c_master_model.xfer(ad_w | 8'h01, 1'b1, rx, ack);
		i_xp_i2c_master_model.xfer(8'hFF, 1'b1, rx, ack);
		i_xp_i2c_master_model.stop();
		`CHK("serial dir read", 8'h0F, rx)
		i_xp_i2c_master_model.start();
		i_xp_i2c_master_model.xfer(ad_w, 1'b1, rx, ack);
		i_xp_i2c_master_model.xfer({6'h0, `XP_CMD_INPUT}, 1'b1, rx, ack);
		i_xp_i2c_master_model.start();
		i_xp_i2c_master_model.xfer(ad_w | 8'h01, 1'b1, rx, ack);
		i_xp_i2c_master_model.xfer(8'hFF, 1'b1, rx, ack);
		i_xp_i2c_master_model.stop();
		`CHK("serial input read", 8'h0A, rx)
		cyc(4);
		`CHK("int after serial read", 1'b0, int_oe)
		i_xp_i2c_master_model.start();
		i_xp_i2c_master_model.xfer({`XP_ADDR_FIXED, 3'b100, 1'b0}, 1'b1, rx, ack);
		i_xp_i2c_master_model.stop();
		`CHK("foreign addr", 1'b1, ack)
		av(1'b0, `XP_AV_STAT, 8'h00);
		`CHK("serial status", 32'h6, q & 32'h6)
		$display("test serial done");
		srst_i <= 1'b1;
		cyc(3);
		srst_i <= 1'b0;
		cyc(2);
		`CHK("reset release pins", 8'h00, p_oe)
		`CHK("reset out latch", 8'hFF, p_o)
		av(1'b0, `XP_AV_DIR, 8'h00);
		`CHK("reset dir", 32'hFF, q)
		av(1'b0, `XP_AV_POLAR, 8'h00);
		`CHK("reset polarity", 32'h0, q)
		$display("test mid-run reset done");
		final_report();
	end
endmodule : xp_expander_tb_top
`default_nettype wire

//--- xp_i2c_master_model.sv
// two-wire bus master model facing the expander's serial link
`timescale 1ns/10ps
`default_nettype none

module xp_i2c_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_o
);
	// ------------------------------------------------------------
	// link timing: a quarter of the 320 ns bit period
	// ------------------------------------------------------------
	initial begin
		scl_o    = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic qtr;
		repeat (2) @(posedge clk_i);
	endtask : qtr

	// ------------------------------------------------------------
	// framing; clock stands high between frames
	// ------------------------------------------------------------
	task automatic start;
		sda_oe_o <= 1'b0;
		qtr();
		scl_o <= 1'b1;
		qtr();
		sda_oe_o <= 1'b1; // data falls while clock high
		qtr();
		scl_o <= 1'b0;
		qtr();
	endtask : start

	task automatic stop;
		sda_oe_o <= 1'b1;
		qtr();
		scl_o <= 1'b1;
		qtr();
		sda_oe_o <= 1'b0;
		qtr();
	endtask : stop

	// data held over the whole high phase, sampled mid-phase
	task automatic bit_xfer(input logic b, output logic s);
		sda_oe_o <= ~b;
		qtr();
		scl_o <= 1'b1;
		qtr();
		s = sda_i;
		qtr();
		scl_o <= 1'b0;
		qtr();
	endtask : bit_xfer

	// send ff to read; ack_in 1 releases the ninth bit
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(tx[i], rx[i]); // msb first
		end
		bit_xfer(ack_in, ack_out);
	endtask : xfer
endmodule : xp_i2c_master_model
`default_nettype wire

//--- xp_pin_cell.sv
// one port pin: drive, release and polarity-corrected sample
`timescale 1ns/10ps
`default_nettype none

module xp_pin_cell (
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	input  wire logic dir_i,
	input  wire logic out_i,
	input  wire logic pol_i,
	input  wire logic pin_i,
	output logic      pin_o,
	output logic      pin_oe_o,
	output logic      in_o
);

	// pins float at reset so nothing fights the pull-up
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pin_o    <= 1'b1;
			pin_oe_o <= 1'b0;
			in_o     <= 1'b0;
		end else begin
			pin_o    <= out_i;
			pin_oe_o <= ~dir_i;
			in_o     <= pin_i ^ pol_i;
		end
	end

endmodule : xp_pin_cell

`default_nettype wire

//--- xp_pkg.sv
// types of the serial i/o expander
`default_nettype none
package xp_pkg;

	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_ADDR  = 9'h002,
		ST_ACK_A = 9'h004,
		ST_CMD   = 9'h008,
		ST_ACK_C = 9'h010,
		ST_WDATA = 9'h020,
		ST_ACK_W = 9'h040,
		ST_RDATA = 9'h080,
		ST_RACK  = 9'h100
	} xp_state_type;

endpackage : xp_pkg

`default_nettype wire

//--- xp_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none

module xp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk_i,
	input  wire logic             srst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			// idle-high reset level: no false edge or pin change after reset
			meta_r <= '1;
			q_o    <= '1;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end

endmodule : xp_sync

`default_nettype wire
